// *** inc/soc_pkg.sv ***
// Constants for the synthesizer output configuration register bank
package soc_pkg;
    localparam int WORD_W          = 32;
    localparam int SEL_W           = 3;
    // Register-select codes in the low bits of each loaded word
    localparam logic [2:0] SEL_REG0 = 3'h0;
    localparam logic [2:0] SEL_REG1 = 3'h1;
    localparam logic [2:0] SEL_REG2 = 3'h2;
    localparam logic [2:0] SEL_OUT  = 3'h4;
    localparam logic [2:0] SEL_LOCK = 3'h5;
    // Word 0 fields
    localparam int INT_LSB   = 15;
    localparam int INT_W     = 16;
    localparam int NUM_LSB   = 3;
    localparam int NUM_W     = 12;
    // Word 1 fields
    localparam int DEN_LSB   = 3;
    localparam int DEN_W     = 12;
    // Word 2 fields
    localparam int DBL_BIT   = 25;
    localparam int HALF_BIT  = 24;
    localparam int RCNT_LSB  = 14;
    localparam int RCNT_W    = 10;
    localparam int DBUF_BIT  = 13;
    // Output stage configuration fields
    localparam int FBSEL_BIT = 23;
    localparam int DIVS_LSB  = 20;
    localparam int DIVS_W    = 3;
    localparam int BSCD_LSB  = 12;
    localparam int BSCD_W    = 8;
    localparam int VCOPD_BIT = 11;
    localparam int MTLD_BIT  = 10;
    localparam int AUXS_BIT  = 9;
    localparam int AUXE_BIT  = 8;
    localparam int AUXP_LSB  = 6;
    localparam int PWR_W     = 2;
    localparam int RFE_BIT   = 5;
    localparam int RFP_LSB   = 3;
    // Lock-detect pin configuration field
    localparam int LDPIN_LSB = 22;
    localparam int LDPIN_W   = 2;
    // Reset values
    localparam logic [WORD_W-1:0] OUT_RST  = 32'h0000_0000;
    localparam logic [WORD_W-1:0] LOCK_RST = 32'h0000_0000;
    // Output divider ratio width (largest ratio 64)
    localparam int RATIO_W   = 7;
    localparam logic [2:0] DIVS_MAX = 3'h6;
endpackage

// *** hdl/soc_cfg.sv ***
// Output and lock-detect configuration decode of the synthesizer
// What this block does
// - Select 100 updates output config register only
// - DB23 chooses oscillator or divider feedback
// - DB22:DB20 selects output divider ratio
// - DB19:DB12 divides reference for band clock
// - DB11 powers oscillator down or up
// - DB10 mutes RF stage until lock
// - DB9 picks divided or fundamental aux source
// - DB8 enables auxiliary output
// - DB7:DB6 sets auxiliary power level
// - DB5 enables primary RF output
// - DB4:DB3 sets primary power level
// - Select 101 updates lock-detect config only
// - DB23:DB22 choose lock pin function
// - Phase clock from R and halving; doubler bit is only reported
// - Output frequency from INT, fraction, divider
// - Fractional modulus is a 12-bit field
// - Halving gives 50% duty phase clock
// - DB13 double buffers the divider field
module soc_cfg
    import soc_pkg::*;
(
    input  wire logic                      i_clock,
    input  wire logic                      i_sys_rst,
    input  wire logic                      i_word_load,
    input  wire logic [soc_pkg::WORD_W-1:0] i_word,
    input  wire logic                      i_lock_detect,
    input  wire logic                      i_ref_pulse,
    output logic                           o_fb_from_osc,
    output logic [soc_pkg::RATIO_W-1:0]    o_out_div_ratio,
    output logic                           o_osc_power_down,
    output logic                           o_rf_stage_powered,
    output logic                           o_aux_fundamental,
    output logic                           o_aux_enable,
    output logic [soc_pkg::PWR_W-1:0]      o_aux_power,
    output logic                           o_rf_enable,
    output logic [soc_pkg::PWR_W-1:0]      o_rf_power,
    output logic [soc_pkg::LDPIN_W-1:0]    o_lock_pin_mode,
    output logic                           o_band_clk_en,
    output logic                           o_pfd_clk,
    output logic                           o_ref_doubled,
    output logic [soc_pkg::RCNT_W:0]       o_pfd_ref_div,
    output logic [31:0]                    o_n_numerator,
    output logic [soc_pkg::DEN_W-1:0]      o_fractional_modulus
);
    import soc_pkg::*;

    logic [WORD_W-1:0]   output_stage_config_r;
    logic [WORD_W-1:0]   lock_pin_config_r;
    logic [INT_W-1:0]    int_r;
    logic [NUM_W-1:0]    fraction_numerator_r;
    logic [DEN_W-1:0]    fractional_modulus_r;
    logic                dbl_r;
    logic                half_r;
    logic [RCNT_W-1:0]   rcnt_r;
    logic                dbuf_r;
    logic [DIVS_W-1:0]   divs_act_r;
    logic [RCNT_W-1:0]   rdiv_cnt_r;
    logic                rout_r;
    logic [BSCD_W-1:0]   bs_cnt_r;
    logic                pfd_tgl_r;
    logic [SEL_W-1:0]    sel;
    logic                ld_out;
    logic                ld_lock;
    logic [DIVS_W-1:0]   divs_new;
    logic [BSCD_W-1:0]   bs_div;
    logic [RCNT_W-1:0]   r_div;

    assign sel      = i_word[SEL_W-1:0];
    assign ld_out   = i_word_load && (sel == SEL_OUT);
    assign ld_lock  = i_word_load && (sel == SEL_LOCK);
    assign divs_new = i_word[DIVS_LSB +: DIVS_W];
    // A zero divider value is taken as divide by one
    assign bs_div   = (output_stage_config_r[BSCD_LSB +: BSCD_W] == '0) ? 8'h01
                      : output_stage_config_r[BSCD_LSB +: BSCD_W];
    assign r_div    = (rcnt_r == '0) ? 10'h001 : rcnt_r;

    // Output stage configuration word; other codes leave it alone
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            output_stage_config_r <= OUT_RST;
        end
        else if (ld_out)
        begin
            output_stage_config_r <= i_word;
        end
    end

    // Lock-detect pin configuration word
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            lock_pin_config_r <= LOCK_RST;
        end
        else if (ld_lock)
        begin
            lock_pin_config_r <= i_word;
        end
    end

    // Counter words that the frequency relations need
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            int_r                <= '0;
            fraction_numerator_r <= '0;
            fractional_modulus_r <= '0;
            dbl_r                <= 1'b0;
            half_r               <= 1'b0;
            rcnt_r               <= '0;
            dbuf_r               <= 1'b0;
        end
        else if (i_word_load)
        begin
            case (sel)
                SEL_REG0:
                begin
                    int_r                <= i_word[INT_LSB +: INT_W];
                    fraction_numerator_r <= i_word[NUM_LSB +: NUM_W];
                end
                SEL_REG1:
                begin
                    fractional_modulus_r <= i_word[DEN_LSB +: DEN_W];
                end
                SEL_REG2:
                begin
                    dbl_r  <= i_word[DBL_BIT];
                    half_r <= i_word[HALF_BIT];
                    rcnt_r <= i_word[RCNT_LSB +: RCNT_W];
                    dbuf_r <= i_word[DBUF_BIT];
                end
                // Output and lock words and unused codes leave these alone
                default:
                begin
                    int_r <= int_r;
                end
            endcase
        end
    end

    // Active divider select: direct, or held until the next word-0 load
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            divs_act_r <= '0;
        end
        else if (ld_out && !dbuf_r)
        begin
            divs_act_r <= divs_new;
        end
        else if (dbuf_r && i_word_load && (sel == SEL_REG0))
        begin
            divs_act_r <= output_stage_config_r[DIVS_LSB +: DIVS_W];
        end
    end

    // Reference counter: one output pulse every R reference events
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            rdiv_cnt_r <= '0;
            rout_r     <= 1'b0;
        end
        else
        begin
            // Counter output is a single-cycle pulse
            rout_r <= 1'b0;
            if (i_ref_pulse)
            begin
                if (rdiv_cnt_r >= r_div - 10'h001)
                begin
                    rdiv_cnt_r <= '0;
                    rout_r     <= 1'b1;
                end
                else
                begin
                    rdiv_cnt_r <= rdiv_cnt_r + 10'h001;
                end
            end
        end
    end

    // Band-select clock enable: R counter output divided by the field
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            bs_cnt_r      <= '0;
            o_band_clk_en <= 1'b0;
        end
        else
        begin
            o_band_clk_en <= 1'b0;
            if (rout_r)
            begin
                if (bs_cnt_r >= bs_div - 8'h01)
                begin
                    bs_cnt_r      <= '0;
                    o_band_clk_en <= 1'b1;
                end
                else
                begin
                    bs_cnt_r <= bs_cnt_r + 8'h01;
                end
            end
        end
    end

    // Phase clock: toggle flip-flop when halving, else the R counter pulse
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            pfd_tgl_r <= 1'b0;
            o_pfd_clk <= 1'b0;
        end
        else
        begin
            if (rout_r)
            begin
                pfd_tgl_r <= ~pfd_tgl_r;
            end
            if (half_r)
            begin
                o_pfd_clk <= rout_r ? ~pfd_tgl_r : pfd_tgl_r;
            end
            else
            begin
                o_pfd_clk <= rout_r;
            end
        end
    end

    // Decoded output stage controls
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            o_fb_from_osc      <= 1'b0;
            // Divide by one until a divider code arrives
            o_out_div_ratio    <= 7'h01;
            o_osc_power_down   <= 1'b0;
            o_rf_stage_powered <= 1'b0;
            o_aux_fundamental  <= 1'b0;
            o_aux_enable       <= 1'b0;
            o_aux_power        <= '0;
            o_rf_enable        <= 1'b0;
            o_rf_power         <= '0;
            o_lock_pin_mode    <= '0;
        end
        else
        begin
            o_fb_from_osc      <= output_stage_config_r[FBSEL_BIT];
            // Codes above the largest ratio are clamped to divide by 64
            o_out_div_ratio    <= RATIO_W'(1) << ((divs_act_r > DIVS_MAX)
                                  ? DIVS_MAX : divs_act_r);
            o_osc_power_down   <= output_stage_config_r[VCOPD_BIT];
            // A muted stage also stays off while disabled or powered down
            o_rf_stage_powered <= output_stage_config_r[RFE_BIT]
                                  && !output_stage_config_r[VCOPD_BIT]
                                  && (!output_stage_config_r[MTLD_BIT]
                                      || i_lock_detect);
            o_aux_fundamental  <= output_stage_config_r[AUXS_BIT];
            o_aux_enable       <= output_stage_config_r[AUXE_BIT];
            o_aux_power        <= output_stage_config_r[AUXP_LSB +: PWR_W];
            o_rf_enable        <= output_stage_config_r[RFE_BIT];
            o_rf_power         <= output_stage_config_r[RFP_LSB +: PWR_W];
            o_lock_pin_mode    <= lock_pin_config_r[LDPIN_LSB +: LDPIN_W];
        end
    end

    // Frequency relation terms: f_pfd = ref*doubled/div, N = numer/modulus
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            o_ref_doubled        <= 1'b0;
            o_pfd_ref_div        <= '0;
            o_n_numerator        <= '0;
            o_fractional_modulus <= '0;
        end
        else
        begin
            o_ref_doubled        <= dbl_r;
            // Halving doubles the effective reference divide
            o_pfd_ref_div        <= half_r ? {r_div, 1'b0} : {1'b0, r_div};
            o_n_numerator        <= 32'(int_r) * 32'(fractional_modulus_r)
                                    + 32'(fraction_numerator_r);
            o_fractional_modulus <= fractional_modulus_r;
        end
    end
endmodule

// *** verif/soc_cfg_assertions.sv ***
// Concurrent checks on the ports of the configuration block
module soc_cfg_chk (
    input wire logic        i_clock,
    input wire logic        i_sys_rst,
    input wire logic        i_word_load,
    input wire logic [31:0] i_word,
    input wire logic        i_ref_pulse,
    input wire logic        o_fb_from_osc,
    input wire logic [6:0]  o_out_div_ratio,
    input wire logic        o_rf_stage_powered,
    input wire logic        o_rf_enable,
    input wire logic [1:0]  o_rf_power,
    input wire logic [1:0]  o_lock_pin_mode,
    input wire logic        o_band_clk_en
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    wire ld4 = i_word_load && i_word[2:0] == 3'h4;
    wire ld5 = i_word_load && i_word[2:0] == 3'h5;
    wire ldx = i_word_load && !ld4 && !ld5;
    property p_fb; ld4 |-> ##2 o_fb_from_osc == $past(i_word[23], 2); endproperty
    a_fb: assert property (p_fb) else $error("feedback select mismatch");
    property p_rfe; ld4 |-> ##2 o_rf_enable == $past(i_word[5], 2); endproperty
    a_rfe: assert property (p_rfe) else $error("rf enable mismatch");
    property p_rfp; ld4 |-> ##2 o_rf_power == $past(i_word[4:3], 2); endproperty
    a_rfp: assert property (p_rfp) else $error("rf power mismatch");
    property p_lock; ld5 |-> ##2 o_lock_pin_mode == $past(i_word[23:22], 2); endproperty
    a_lock: assert property (p_lock) else $error("lock pin mode mismatch");
    property p_stage; o_rf_stage_powered |-> o_rf_enable; endproperty
    a_stage: assert property (p_stage) else $error("stage powered while disabled");
    property p_other;
        ldx |-> ##2 $stable(o_fb_from_osc) && $stable(o_rf_power) && $stable(o_lock_pin_mode);
    endproperty
    a_other: assert property (p_other) else $error("ignored word changed config");
    property p_ratio; $onehot(o_out_div_ratio); endproperty
    a_ratio: assert property (p_ratio) else $error("divider ratio not a power of two");
    property p_band; o_band_clk_en |-> $past(i_ref_pulse, 2); endproperty
    a_band: assert property (p_band) else $error("band clock without reference");
endmodule

bind soc_cfg soc_cfg_chk u_chk (.i_clock, .i_sys_rst, .i_word_load, .i_word, .i_ref_pulse,
    .o_fb_from_osc, .o_out_div_ratio, .o_rf_stage_powered, .o_rf_enable, .o_rf_power,
    .o_lock_pin_mode, .o_band_clk_en);

// *** verif/soc_host.sv ***
// Host model that loads control words into the configuration block
module soc_host (
    input  wire logic        i_clock,
    output logic             o_word_load,
    output logic [31:0]      o_word
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        o_word_load = 1'b0;
        o_word = 32'h0;
    end
    task automatic send(input logic [31:0] w);
        @(posedge i_clock) #5;
        o_word_load = 1'b1;
        o_word = w;
        @(posedge i_clock) #5;
        o_word_load = 1'b0;
        o_word = ~w; // Bus no longer holds the word once the load is done
    endtask
    // Power-up order, highest register first
    task automatic init(input logic [31:0] w5, w4, w3, w2, w1, w0);
        send(w5);
        send(w4);
        send(w3);
        send(w2);
        send(w1);
        send(w0);
    endtask
endmodule

// *** verif/tb_soc_cfg.sv ***
// Self-checking bench for the output configuration block
module tb_soc_cfg;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clock = 1'b0, i_sys_rst = 1'b1, i_lock_detect = 1'b0, i_ref_pulse = 1'b0;
    logic i_word_load, o_fb_from_osc, o_osc_power_down, o_rf_stage_powered;
    logic o_aux_fundamental, o_aux_enable, o_rf_enable, o_band_clk_en, o_pfd_clk;
    logic o_ref_doubled, pfd_q;
    logic [31:0] i_word, o_n_numerator;
    logic [6:0]  o_out_div_ratio;
    logic [1:0]  o_aux_power, o_rf_power, o_lock_pin_mode;
    logic [10:0] o_pfd_ref_div;
    logic [11:0] o_fractional_modulus;
    int err_count = 0, comparisons = 0, n_pfd = 0, n_band = 0;
    // Modulus 25, R 3 with doubler: phase clock and band clock stay in range
    localparam logic [31:0] W4 = 32'h00B0_23BC, W2 = 32'h0200_C002, W0 = 32'h00D3_0068;

    soc_cfg dut (.i_clock, .i_sys_rst, .i_word_load, .i_word, .i_lock_detect, .i_ref_pulse,
        .o_fb_from_osc, .o_out_div_ratio, .o_osc_power_down, .o_rf_stage_powered,
        .o_aux_fundamental, .o_aux_enable, .o_aux_power, .o_rf_enable, .o_rf_power,
        .o_lock_pin_mode, .o_band_clk_en, .o_pfd_clk, .o_ref_doubled, .o_pfd_ref_div,
        .o_n_numerator, .o_fractional_modulus);
    soc_host host (.i_clock, .o_word_load(i_word_load), .o_word(i_word));

    initial forever #50 i_clock = ~i_clock;
    always @(posedge i_clock)
    begin
        n_band += o_band_clk_en;
        if (o_pfd_clk && !pfd_q) n_pfd++;
        pfd_q = o_pfd_clk;
    end

    task automatic chk(input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle;
        repeat (3) @(posedge i_clock);
        #5;
    endtask
    task automatic final_report;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic t_init;
        chk({o_out_div_ratio, o_rf_enable, o_fractional_modulus}, 20'h02000);
        host.init(32'h0080_0005, W4, 32'h3, W2, 32'hC9, W0);
        settle;
        chk(o_lock_pin_mode, 2'h2);
        chk({o_fb_from_osc, o_aux_fundamental, o_aux_enable, o_aux_power}, 5'h1E);
        chk({o_rf_enable, o_rf_power, o_osc_power_down}, 4'hE);
        chk(o_out_div_ratio, 7'h08);
        chk(o_n_numerator, 32'h2943);
        chk(o_fractional_modulus, 12'h019);
        chk({o_ref_doubled, o_pfd_ref_div}, 12'h803);
        chk(o_rf_stage_powered, 1'b1);
        $display("t_init done");
    endtask
    task automatic t_sel;
        for (int c = 0; c < 8; c++)
            if (c != 4 && c != 5)
            begin
                host.send({29'h1FFF_FFFF, c[2:0]});
                settle;
                chk({o_fb_from_osc, o_rf_power, o_lock_pin_mode}, 5'h1E);
            end
        host.send(32'h0040_0005);
        settle;
        chk({o_fb_from_osc, o_rf_power, o_lock_pin_mode}, 5'h1D);
        $display("t_sel done");
    endtask
    task automatic t_mute;
        host.send(32'h0030_0424);
        settle;
        chk({o_rf_stage_powered, o_rf_enable, o_lock_pin_mode}, 4'h5);
        chk(o_fb_from_osc, 1'b0);
        i_lock_detect = 1'b1;
        repeat (2) @(posedge i_clock);
        #5;
        chk(o_rf_stage_powered, 1'b1);
        host.send(32'h0030_0C24);
        settle;
        chk({o_osc_power_down, o_rf_stage_powered}, 2'h2);
        i_lock_detect = 1'b0;
        $display("t_mute done");
    endtask
    task automatic t_dbuf;
        host.send(W2 | 32'h2000);
        host.send(32'h0050_0024);
        settle;
        chk(o_out_div_ratio, 7'h08);
        host.send(W0);
        settle;
        chk(o_out_div_ratio, 7'h20);
        $display("t_dbuf done");
    endtask
    task automatic pulses(input logic [31:0] w2);
        host.send(w2);
        settle;
        n_pfd = 0;
        n_band = 0;
        repeat (12)
        begin
            i_ref_pulse = 1'b1;
            @(posedge i_clock) #5;
            i_ref_pulse = 1'b0;
            @(posedge i_clock) #5;
        end
        settle;
    endtask
    task automatic t_ref;
        host.send(32'h0050_2024);
        pulses(W2);
        chk(n_pfd, 32'h4);
        chk(n_band, 32'h2);
        pulses(W2 | 32'h0100_0000);
        chk(n_pfd, 32'h2);
        chk(o_pfd_ref_div, 11'h006);
        $display("t_ref done");
    endtask

    initial
    begin
        repeat (3) @(posedge i_clock);
        #5;
        i_sys_rst = 1'b0;
        t_init;
        t_sel;
        t_mute;
        t_dbuf;
        t_ref;
        final_report;
    end
    initial
    begin
        #300000;
        err_count++;
        final_report;
    end
endmodule
